//--- include/acdoc_pkg.sv
// shared constants for the adaptive clock divider and output control block
package acdoc_pkg;
  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int M_W = 4;
  localparam int I_W = 3;
  localparam int FREQ_W = 24;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CLOCK_OUTPUT_CONTROL = 16'hffe1;
  localparam logic [IDX_W-1:0] IDX_GEN1_DIVIDER_CONTROL = 16'hffe2;
  localparam logic [IDX_W-1:0] IDX_GEN2_DIVIDER_CONTROL = 16'hfff6;
  localparam logic [IDX_W-1:0] IDX_GEN2_FREQ_WORD_HIGH = 16'hfff7;
  localparam logic [IDX_W-1:0] IDX_GEN2_FREQ_WORD_MID = 16'hfff8;
  localparam logic [IDX_W-1:0] IDX_GEN2_FREQ_WORD_LOW = 16'hfff9;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_OUT_TWO_EN = 7;
  localparam int POS_OUT_ONE_EN = 6;
  localparam int POS_OUT_ONE_SRC = 3;
  localparam int POS_DIV_EN = 2;
  localparam int POS_OUT_TWO_SRC = 0;
  localparam int POS_POST_SYNTH_DIVIDE_RATIO = 4;
  localparam int POS_INPUT_CLOCK_DIVIDE_RATIO = 0;
  // ---------------------------------------------------------------
  // reset values and responses
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock source selector codes
  localparam logic [1:0] SRC_GEN = 2'h0;
  localparam logic [1:0] SRC_MCLK = 2'h2;
endpackage

//--- core/acdoc_div.sv
// edge-counting clock divider, divides its source by ratio plus one
`timescale 1ns/1ns
module acdoc_div #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic enable,
  input wire logic [W-1:0] ratio,
  // clocks
  input wire logic src,
  output logic divided
);
  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  // both edges are counted so odd ratios still give a true divide by n
  logic src_q;
  logic [W-1:0] count;
  wire src_edge = src ^ src_q;
  wire at_end = (count == ratio);
  wire [W-1:0] count_inc = count + {{(W-1){1'h0}}, 1'h1};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 1'h0;
      count <= '0;
      divided <= 1'h0;
    end else begin
      src_q <= src;
      if (!enable) begin
        count <= '0; // R5
        divided <= 1'h0; // R5
      end else if (src_edge) begin
        count <= at_end ? '0 : count_inc; // R1
        divided <= at_end ? ~divided : divided; // R1
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  div_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1 R3 R4
    (enable && src_edge && at_end) |=> divided != $past(divided))
    else $error("divider did not toggle at end of count");
  div_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1 R3 R4
    (enable && src_edge && !at_end) |=> divided == $past(divided))
    else $error("divider toggled before end of count");
  div_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    !enable |=> !divided && count == '0)
    else $error("divider active while disabled");
  div_run_c: cover property (@(posedge aclk) disable iff (!aresetn)
    enable && src_edge && at_end && ratio != '0);
endmodule // acdoc_div

//--- core/acdoc_top.sv
// adaptive clock divider and output control with axi4-lite registers
// How it works
// R1 - second generator output divides by its four-bit ratio code plus one, 1 to 16
// R2 - second generator divider register low four bits read zero, ignore writes
// R3 - first generator ratio in bits 7 to 4, divides by code plus one
// R4 - bits 2 to 0 divide the master clock by code plus one, 1 to 8
// R5 - all divider circuits run only while the divider enable bit is one
// R6 - source select: 00 generator, x1 divided master clock, 10 raw master clock
// R7 - a clock output drives its source only when enabled, else logic zero
// R8 - 24-bit synthesizer word over three byte registers, high byte in byte two
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module acdoc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [acdoc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [acdoc_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [acdoc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [acdoc_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock sources, sampled as synchronous levels
  input wire logic mclk_in,
  input wire logic gen1_synth_clk,
  input wire logic gen2_synth_clk,
  // outputs
  output logic clock_out_one,
  output logic clock_out_two,
  output logic [acdoc_pkg::FREQ_W-1:0] synth_frequency_word
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [acdoc_pkg::REG_W-1:0] clock_output_control;
  logic [acdoc_pkg::M_W-1:0] gen1_post_synth_divide_ratio;
  logic [acdoc_pkg::I_W-1:0] input_clock_divide_ratio;
  logic [acdoc_pkg::M_W-1:0] gen2_post_synth_divide_ratio;

  wire clock_out_two_enable = clock_output_control[acdoc_pkg::POS_OUT_TWO_EN];
  wire clock_out_one_enable = clock_output_control[acdoc_pkg::POS_OUT_ONE_EN];
  wire divider_circuits_enable = clock_output_control[acdoc_pkg::POS_DIV_EN];
  wire [1:0] clock_out_one_source = clock_output_control[acdoc_pkg::POS_OUT_ONE_SRC +: 2];
  wire [1:0] clock_out_two_source = clock_output_control[acdoc_pkg::POS_OUT_TWO_SRC +: 2];

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  // address and data may arrive in either order, each is parked until both are here
  logic aw_held;
  logic w_held;
  logic [acdoc_pkg::IDX_W-1:0] waddr_idx;
  logic [acdoc_pkg::REG_W-1:0] wbyte;
  logic wlane;

  wire aw_fire = awvalid && awready;
  wire w_fire = wvalid && wready;
  wire do_write = aw_held && w_held && !bvalid;
  wire next_aw_held = (aw_held || aw_fire) && !do_write;
  wire next_w_held = (w_held || w_fire) && !do_write;
  wire next_bvalid = do_write || (bvalid && !bready);

  wire wsel_ctl = (waddr_idx == acdoc_pkg::IDX_CLOCK_OUTPUT_CONTROL);
  wire wsel_g1 = (waddr_idx == acdoc_pkg::IDX_GEN1_DIVIDER_CONTROL);
  wire wsel_g2 = (waddr_idx == acdoc_pkg::IDX_GEN2_DIVIDER_CONTROL);
  wire wsel_hi = (waddr_idx == acdoc_pkg::IDX_GEN2_FREQ_WORD_HIGH);
  wire wsel_mid = (waddr_idx == acdoc_pkg::IDX_GEN2_FREQ_WORD_MID);
  wire wsel_lo = (waddr_idx == acdoc_pkg::IDX_GEN2_FREQ_WORD_LOW);
  wire wsel_any = wsel_ctl || wsel_g1 || wsel_g2 || wsel_hi || wsel_mid || wsel_lo;
  wire wr_en = do_write && wlane;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      awready <= 1'h0;
      wready <= 1'h0;
      bvalid <= 1'h0;
      bresp <= acdoc_pkg::RESP_OKAY;
      waddr_idx <= '0;
      wbyte <= acdoc_pkg::RST_REG;
      wlane <= 1'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= !next_aw_held;
      wready <= !next_w_held;
      bvalid <= next_bvalid;
      if (aw_fire) begin
        waddr_idx <= awaddr[acdoc_pkg::ADDR_W-1:2];
      end
      if (w_fire) begin
        wbyte <= wdata[acdoc_pkg::REG_W-1:0];
        wlane <= wstrb[0];
      end
      if (do_write) begin
        bresp <= wsel_any ? acdoc_pkg::RESP_OKAY : acdoc_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_output_control <= acdoc_pkg::RST_REG;
      gen1_post_synth_divide_ratio <= '0;
      input_clock_divide_ratio <= '0;
      gen2_post_synth_divide_ratio <= '0;
      synth_frequency_word <= '0;
    end else if (wr_en) begin
      if (wsel_ctl) begin
        // bit 5 is reserved and never stored
        clock_output_control <= wbyte & 8'hdf;
      end
      if (wsel_g1) begin
        gen1_post_synth_divide_ratio <= wbyte[acdoc_pkg::POS_POST_SYNTH_DIVIDE_RATIO +: acdoc_pkg::M_W]; // R3
        input_clock_divide_ratio <= wbyte[acdoc_pkg::POS_INPUT_CLOCK_DIVIDE_RATIO +: acdoc_pkg::I_W]; // R4
      end
      if (wsel_g2) begin
        gen2_post_synth_divide_ratio <= wbyte[acdoc_pkg::POS_POST_SYNTH_DIVIDE_RATIO +: acdoc_pkg::M_W]; // R2
      end
      if (wsel_hi) begin
        synth_frequency_word[23:16] <= wbyte; // R8
      end
      if (wsel_mid) begin
        synth_frequency_word[15:8] <= wbyte; // R8
      end
      if (wsel_lo) begin
        synth_frequency_word[7:0] <= wbyte; // R8
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  wire [acdoc_pkg::IDX_W-1:0] raddr_idx = araddr[acdoc_pkg::ADDR_W-1:2];
  wire rsel_ctl = (raddr_idx == acdoc_pkg::IDX_CLOCK_OUTPUT_CONTROL);
  wire rsel_g1 = (raddr_idx == acdoc_pkg::IDX_GEN1_DIVIDER_CONTROL);
  wire rsel_g2 = (raddr_idx == acdoc_pkg::IDX_GEN2_DIVIDER_CONTROL);
  wire rsel_hi = (raddr_idx == acdoc_pkg::IDX_GEN2_FREQ_WORD_HIGH);
  wire rsel_mid = (raddr_idx == acdoc_pkg::IDX_GEN2_FREQ_WORD_MID);
  wire rsel_lo = (raddr_idx == acdoc_pkg::IDX_GEN2_FREQ_WORD_LOW);
  wire rsel_any = rsel_ctl || rsel_g1 || rsel_g2 || rsel_hi || rsel_mid || rsel_lo;
  wire [7:0] g1_view = {gen1_post_synth_divide_ratio, 1'h0, input_clock_divide_ratio};
  wire [7:0] g2_view = {gen2_post_synth_divide_ratio, 4'h0}; // R2
  wire [7:0] rd_byte = rsel_ctl ? clock_output_control :
                       rsel_g1 ? g1_view :
                       rsel_g2 ? g2_view :
                       rsel_hi ? synth_frequency_word[23:16] :
                       rsel_mid ? synth_frequency_word[15:8] :
                       rsel_lo ? synth_frequency_word[7:0] : 8'h00;
  wire ar_fire = arvalid && arready;
  wire next_rvalid = ar_fire || (rvalid && !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h0;
      rvalid <= 1'h0;
      rdata <= '0;
      rresp <= acdoc_pkg::RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (ar_fire) begin
        rdata <= {24'h000000, rd_byte};
        rresp <= rsel_any ? acdoc_pkg::RESP_OKAY : acdoc_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  logic gen1_div_clk;
  logic gen2_div_clk;
  logic mclk_div_clk;

  acdoc_div #(.W(acdoc_pkg::M_W)) u_gen1_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(divider_circuits_enable), // R5
    .ratio(gen1_post_synth_divide_ratio), // R3
    .src(gen1_synth_clk),
    .divided(gen1_div_clk)
  );
  acdoc_div #(.W(acdoc_pkg::M_W)) u_gen2_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(divider_circuits_enable), // R5
    .ratio(gen2_post_synth_divide_ratio), // R1
    .src(gen2_synth_clk),
    .divided(gen2_div_clk)
  );
  acdoc_div #(.W(acdoc_pkg::I_W)) u_mclk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(divider_circuits_enable), // R5
    .ratio(input_clock_divide_ratio), // R4
    .src(mclk_in),
    .divided(mclk_div_clk)
  );

  // ---------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------
  // outputs are retimed by one aclk, so edges carry one cycle of latency and aclk jitter
  wire sel_one = clock_out_one_source[0] ? mclk_div_clk :
                 clock_out_one_source[1] ? mclk_in : gen1_div_clk; // R6
  wire sel_two = clock_out_two_source[0] ? mclk_div_clk :
                 clock_out_two_source[1] ? mclk_in : gen2_div_clk; // R6

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_out_one <= 1'h0;
      clock_out_two <= 1'h0;
    end else begin
      clock_out_one <= clock_out_one_enable && sel_one; // R7
      clock_out_two <= clock_out_two_enable && sel_two; // R7
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  g2_reserved_a: assert property (ar_fire && rsel_g2 |=> rdata[3:0] == 4'h0) // R2
    else $error("reserved bits of gen2 divider control read nonzero");
  g1_field_a: assert property (wr_en && wsel_g1 |=> // R3 R4
    gen1_post_synth_divide_ratio == $past(wbyte[7:4]) &&
    input_clock_divide_ratio == $past(wbyte[2:0]))
    else $error("gen1 divider fields not stored from bits 7:4 and 2:0");
  g2_field_a: assert property (wr_en && wsel_g2 |=> // R1
    gen2_post_synth_divide_ratio == $past(wbyte[7:4]))
    else $error("gen2 ratio not stored from bits 7:4");
  div_disable_a: assert property (!divider_circuits_enable ##1 !divider_circuits_enable |-> // R5
    !gen1_div_clk && !gen2_div_clk && !mclk_div_clk)
    else $error("divider output active while dividers disabled");
  out_off_a: assert property (!clock_out_one_enable [*2] |-> !clock_out_one) // R7
    else $error("clock output one driven while disabled");
  out_two_off_a: assert property (!clock_out_two_enable |=> !clock_out_two) // R7
    else $error("clock output two driven while disabled");
  src_div_a: assert property (clock_out_two_enable && clock_out_two_source[0] |=> // R6
    clock_out_two == $past(mclk_div_clk))
    else $error("x1 select does not route divided master clock");
  src_raw_a: assert property (clock_out_one_enable && // R6
    clock_out_one_source == acdoc_pkg::SRC_MCLK |=> clock_out_one == $past(mclk_in))
    else $error("10 select does not route master clock");
  src_gen_a: assert property (clock_out_two_enable && // R6
    clock_out_two_source == acdoc_pkg::SRC_GEN |=> clock_out_two == $past(gen2_div_clk))
    else $error("00 select does not route generator output");
  freq_high_a: assert property (wr_en && wsel_hi |=> // R8
    synth_frequency_word[23:16] == $past(wbyte))
    else $error("high frequency byte not stored");
  write_resp_a: assert property (do_write |=> bvalid)
    else $error("write not answered next cycle");

  write_c: cover property (wr_en && wsel_ctl);
  read_c: cover property (ar_fire && rsel_g1 ##1 rvalid);
  out_toggle_c: cover property (clock_out_one ##1 !clock_out_one ##1 clock_out_one);
  unmapped_c: cover property (do_write && !wsel_any);
endmodule // acdoc_top

//--- verif/acdoc_codec_model.sv
// behavioural codec side: free-running source clocks and a clock output period meter
`timescale 1ns/1ns
module acdoc_codec_model #(
  parameter int HALF_MCLK = 4,
  parameter int HALF_GEN1 = 3,
  parameter int HALF_GEN2 = 5
) (
  // clock
  input wire logic aclk,
  // sources toward the block
  output logic mclk_in,
  output logic gen1_synth_clk,
  output logic gen2_synth_clk,
  // clock outputs from the block
  input wire logic clock_out_one,
  input wire logic clock_out_two,
  // measurements, periods in aclk cycles and rising-edge counts
  output int period_one,
  output int period_two,
  output int rises_one,
  output int rises_two
);
  localparam int HALF_LEN [3] = '{HALF_MCLK, HALF_GEN1, HALF_GEN2};
  int half_cnt [3] = '{0, 0, 0};
  int gap [2] = '{0, 0};
  int per [2] = '{0, 0};
  int rises [2] = '{0, 0};
  logic [2:0] srcs = 3'h0;
  logic [1:0] outs;
  logic [1:0] prev_outs = 2'h0;
  assign {gen2_synth_clk, gen1_synth_clk, mclk_in} = srcs;
  assign outs = {clock_out_two, clock_out_one};
  assign period_one = per[0];
  assign period_two = per[1];
  assign rises_one = rises[0];
  assign rises_two = rises[1];
  // sources run free, as a crystal would; they toggle only just after aclk edges
  always @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (half_cnt[i] == HALF_LEN[i] - 1) begin
        half_cnt[i] <= 0;
        srcs[i] <= ~srcs[i];
      end else begin
        half_cnt[i] <= half_cnt[i] + 1;
      end
    end
    prev_outs <= outs;
    for (int i = 0; i < 2; i++) begin
      gap[i] <= gap[i] + 1;
      if (outs[i] === 1'h1 && prev_outs[i] === 1'h0) begin
        per[i] <= gap[i] + 1;
        gap[i] <= 0;
        rises[i] <= rises[i] + 1;
      end
    end
  end
endmodule // acdoc_codec_model

//--- verif/test_adaptive_clock_divider_output_ctl.sv
// self-checking bench for the adaptive clock divider and output control block
`timescale 1ns/1ns
module test_adaptive_clock_divider_output_ctl;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [acdoc_pkg::ADDR_W-1:0] awaddr = 18'h0;
  logic [acdoc_pkg::ADDR_W-1:0] araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, clock_out_one, clock_out_two;
  logic mclk_in, gen1_synth_clk, gen2_synth_clk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] synth_frequency_word;
  int period_one, period_two, rises_one, rises_two;
  int mismatches = 0;
  int comparisons = 0;
  int mdl [int];
  logic [15:0] regs [6] = '{16'hffe1, 16'hffe2, 16'hfff6, 16'hfff7, 16'hfff8, 16'hfff9};
  logic [3:0] mset [4] = '{4'h0, 4'h1, 4'h7, 4'hf};
  logic [3:0] m2;
  logic [1:0] code [2] = '{2'h1, 2'h3};

  always #4 aclk = ~aclk;

  acdoc_top u_acdoc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .mclk_in(mclk_in), .gen1_synth_clk(gen1_synth_clk),
    .gen2_synth_clk(gen2_synth_clk), .clock_out_one(clock_out_one),
    .clock_out_two(clock_out_two), .synth_frequency_word(synth_frequency_word));

  acdoc_codec_model u_acdoc_codec_model (.aclk(aclk), .mclk_in(mclk_in),
    .gen1_synth_clk(gen1_synth_clk), .gen2_synth_clk(gen2_synth_clk),
    .clock_out_one(clock_out_one), .clock_out_two(clock_out_two), .period_one(period_one),
    .period_two(period_two), .rises_one(rises_one), .rises_two(rises_two));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] mask_of(input logic [15:0] idx);
    case (idx)
      16'hffe1: return 8'hdf;
      16'hffe2: return 8'hf7;
      16'hfff6: return 8'hf0;
      default: return 8'hff;
    endcase
  endfunction

  // master holds each channel until its own ready; the model follows the response
  task automatic bus_write(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {8'($urandom()), 16'h0, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid === 1'h1 && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid === 1'h1 && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    cmp(bresp, mdl.exists(idx) ? acdoc_pkg::RESP_OKAY : acdoc_pkg::RESP_SLVERR);
    if (mdl.exists(idx) && s[0]) mdl[idx] = d & mask_of(idx);
    bready <= 1'h0;
  endtask

  task automatic bus_check(input logic [15:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    cmp(rdata, mdl.exists(idx) ? 32'(mdl[idx]) : 32'h0);
    cmp(rresp, mdl.exists(idx) ? acdoc_pkg::RESP_OKAY : acdoc_pkg::RESP_SLVERR);
    rready <= 1'h0;
  endtask

  task automatic check_period(input int which, input int exp);
    repeat (3 * exp + 40) @(posedge aclk);
    cmp(which ? period_two : period_one, exp);
  endtask

  // settle first, since edges already in the retiming stages may still land
  task automatic check_quiet();
    int r1;
    int r2;
    repeat (10) @(posedge aclk);
    r1 = rises_one;
    r2 = rises_two;
    repeat (200) @(posedge aclk);
    cmp(rises_one, r1);
    cmp(rises_two, r2);
    cmp({clock_out_two, clock_out_one}, 32'h0);
  endtask

  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(19));
    foreach (regs[i]) mdl[regs[i]] = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (regs[i]) bus_check(regs[i]);
    foreach (regs[i]) bus_write(regs[i], 8'hff, 4'h1);
    foreach (regs[i]) bus_check(regs[i]);
    bus_write(16'hfffc, 8'h5a, 4'hf);
    bus_check(16'hfffc);
    bus_write(16'hfff6, 8'h00, 4'h0);
    bus_check(16'hfff6);
    for (int k = 0; k < 3; k++) begin
      for (int b = 3; b < 6; b++) bus_write(regs[b], 8'($urandom()), 4'h1);
      cmp(synth_frequency_word, {8'(mdl[16'hfff7]), 8'(mdl[16'hfff8]), 8'(mdl[16'hfff9])});
    end
    mset[2] = 4'($urandom());
    for (int k = 0; k < 4; k++) begin
      m2 = 4'($urandom());
      bus_write(16'hffe2, {mset[k], 4'h0}, 4'h1);
      bus_write(16'hfff6, {m2, 4'h0}, 4'h1);
      bus_write(16'hffe1, 8'hc4, 4'h1);
      check_period(0, 6 * (mset[k] + 1));
      check_period(1, 10 * (m2 + 1));
    end
    for (int i = 0; i < 8; i++) begin
      bus_write(16'hffe2, {4'h3, 1'h0, 3'(i)}, 4'h1);
      foreach (code[c]) begin
        bus_write(16'hffe1, 8'hc4 | {3'h0, code[c], 3'h0} | {6'h0, code[c]}, 4'h1);
        check_period(0, 8 * (i + 1));
        check_period(1, 8 * (i + 1));
      end
    end
    bus_write(16'hffe1, 8'hd6, 4'h1);
    check_period(0, 8);
    check_period(1, 8);
    bus_write(16'hffe1, 8'h04, 4'h1);
    check_quiet();
    bus_write(16'hffe1, 8'hc0, 4'h1);
    check_quiet();
    bus_check(16'hffe1);
    finish_test();
  end

  initial begin
    #(8 * 60000);
    mismatches++;
    finish_test();
  end
endmodule // test_adaptive_clock_divider_output_ctl
